// ---- hdl/ppfac_loop.sv ----
// Power state and fast-acquire release control for one synthesizer loop.
// Assumes load events and pump status are already on the system clock.
`timescale 1ns/10ps
`default_nettype none
module ppfac_loop (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic load_evt, // This loop's divider word latched
   input wire logic pd_new, // Powerdown bit of that word
   input wire logic tri_bit, // Latched pump tristate bit
   input wire logic fast_req, // Fast acquire wanted
   input wire logic pump_idle, // Pump output high-impedance now
   output ppfac_pkg::ppfac_loop_state_t state, // Power state
   output logic powered_down, // Loop bias off
   output logic fast_active // Fast acquire in force
);
   import ppfac_pkg::*;
   typedef struct packed {
      ppfac_loop_state_t st;
      logic fast;
   } ppfac_loop_st_t;
   ppfac_loop_st_t s, n;

   // Next state
   always_comb begin
      n = s;
      if (load_evt && !pd_new) begin
         n.st = LS_ACTIVE;
      end else if (load_evt && s.st == LS_ACTIVE) begin
         n.st = tri_bit ? LS_DOWN : LS_SYNC_WAIT;
      end else begin
         case (s.st)
            LS_ACTIVE: n.st = LS_ACTIVE;
            LS_SYNC_WAIT: n.st = pump_idle ? LS_DOWN : LS_SYNC_WAIT;
            LS_DOWN: n.st = LS_DOWN;
            default: n.st = LS_ACTIVE;
         endcase
      end
      // leave fast acquire only while pump idle
      if (fast_req) begin
         n.fast = 1'b1;
      end else if (pump_idle) begin
         n.fast = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{st: LS_ACTIVE, fast: 1'b0};
      end else begin
         s <= n;
      end
   end

   assign state = s.st;
   assign powered_down = (s.st == LS_DOWN);
   assign fast_active = s.fast;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_pd_load;
      load_evt && pd_new && state == LS_ACTIVE;
   endsequence

   a_async_down_now: assert property (s_pd_load and tri_bit |=> powered_down)
      else $error("Asynchronous powerdown not immediate");
   a_sync_wait_entry: assert property (s_pd_load and !tri_bit |=> state == LS_SYNC_WAIT)
      else $error("Synchronous powerdown not started");
   a_sync_pump_gate: assert property ((state == LS_SYNC_WAIT && !pump_idle && !load_evt)
      |=> !powered_down)
      else $error("Powered down before pump went idle");
   a_wake_now: assert property (load_evt && !pd_new |=> state == LS_ACTIVE ##1 !powered_down)
      else $error("Loop not woken by cleared powerdown bit");
   a_fast_hold: assert property (fast_active && !fast_req && !pump_idle |=> fast_active)
      else $error("Fast acquire dropped while pump active");
endmodule
`default_nettype wire

// ---- hdl/ppfac_sync.sv ----
// Two-flop level synchronizer for a group of asynchronous inputs.
// Assumes inputs are slow levels; no multi-bit coherence is implied.
`timescale 1ns/10ps
`default_nettype none
module ppfac_sync #(
   parameter int W = 1
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic [W-1:0] d, // Asynchronous inputs
   output logic [W-1:0] q // Synchronized outputs
);
   typedef struct packed {
      logic [W-1:0] q1;
      logic [W-1:0] q2;
   } ppfac_sync_st_t;
   ppfac_sync_st_t s, n;

   // Next state: first stage feeds only the second
   always_comb begin
      n = s;
      n.q1 = d;
      n.q2 = s.q1;
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign q = s.q2;
endmodule
`default_nettype wire

// ---- hdl/ppfac_top.sv ----
// Powerdown and fast-acquire controller of a dual-loop synthesizer.
// Assumes serial pins and pump status are asynchronous; bus is AHB-Lite.
// Operation
// - Synchronous powerdown waits until the loop's pump output is high-impedance.
// - Asynchronous powerdown takes effect right at the latch event.
// - A powered-down loop holds its reference and main dividers in load.
// - A powered-down loop debiases its prescaler input to high impedance.
// - Reference oscillator runs unless both loops' powerdown bits are set.
// - Serial shifting and latching keep working in every powerdown mode.
// - Latching a cleared powerdown bit wakes the loop at once.
// - Tristate and powerdown bits pick active, pump off, sync or async down.
// - Fast acquire raises pump current four times, one to four milliamps.
// - Fast acquire pulls the multifunction pin low through open drain.
// - Return to normal current happens in step with the pump output.
// - Fast acquire needs lock selects 0, output selects 1, current bit high.
// - Bits shift in MSB first; load edge fills one of four latches.
// - Tristate bit at powerdown time chooses synchronous or asynchronous mode.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ppfac_top (
   input wire logic clk, // 40 MHz system clock
   input wire logic rst, // Async reset, active high
   // Serial programming pins
   input wire logic ser_clk, // Serial shift clock pin
   input wire logic ser_data, // Serial data pin
   input wire logic load_enable, // Load enable pin
   // Analog loop status, index 0 loop_one, 1 loop_two
   input wire logic [ppfac_pkg::NUM_LOOP-1:0] pump_idle, // Pump output high-impedance
   // Analog loop controls
   output logic [ppfac_pkg::NUM_LOOP-1:0] loop_bias_en, // Loop powered
   output logic [ppfac_pkg::NUM_LOOP-1:0] divider_load, // Hold dividers in load
   output logic [ppfac_pkg::NUM_LOOP-1:0] prescaler_hiz, // Debias prescaler input
   output logic [ppfac_pkg::NUM_LOOP-1:0] pump_tristate, // Force pump high-impedance
   output logic [ppfac_pkg::NUM_LOOP-1:0] pump_x4, // Pump at four times current
   output logic osc_enable, // Reference oscillator on
   output logic multifunction_output_o, // Open-drain level, always low
   output logic multifunction_output_oe, // Pull-down active
   output logic [ppfac_pkg::DATA_W-1:0] ref_word_one, // loop_one reference latch
   output logic [ppfac_pkg::DATA_W-1:0] ref_word_two, // loop_two reference latch
   output logic [ppfac_pkg::DATA_W-1:0] div_word_one, // loop_one divider latch
   output logic [ppfac_pkg::DATA_W-1:0] div_word_two, // loop_two divider latch
   // AHB-Lite slave
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write strobe
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready in
   output logic hreadyout, // Ready out, no wait states
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata // Read data
);
   import ppfac_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] shift;
      logic sclk_d;
      logic load_d;
      logic [NUM_LATCH-1:0][DATA_W-1:0] latch;
      logic wr_pend;
      logic [ADDR_W-1:0] addr;
      logic [31:0] rdata;
   } ppfac_top_st_t;
   ppfac_top_st_t s, n;

   logic [4:0] sync_q;
   logic sclk_rise;
   logic load_rise;
   logic bus_load;
   logic load_evt;
   logic [WORD_W-1:0] load_word;
   logic fast_mode;
   logic addr_phase;
   logic [31:0] status;
   logic [31:0] rd_val;
   logic [NUM_LOOP-1:0] pd_bit;
   logic [NUM_LOOP-1:0] tri_bit;
   logic [NUM_LOOP-1:0] cur_bit;
   logic [NUM_LOOP-1:0] lds_bit;
   logic [NUM_LOOP-1:0] ofs_bit;
   logic [NUM_LOOP-1:0] loop_down;
   logic [NUM_LOOP-1:0] fast_act;
   logic [NUM_LOOP-1:0] loop_load;
   ppfac_loop_state_t [NUM_LOOP-1:0] loop_st;

   // Pins and pump status into the clock domain
   ppfac_sync #(.W(5)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({pump_idle, load_enable, ser_data, ser_clk}),
      .q(sync_q)
   );

   // Edge detection on synchronized serial pins
   assign sclk_rise = sync_q[0] & ~s.sclk_d;
   assign load_rise = sync_q[2] & ~s.load_d;

   // A bus write to the load register acts as a load edge
   assign bus_load = s.wr_pend && (s.addr == OFS_LOAD);
   assign load_evt = load_rise | bus_load;
   assign load_word = load_rise ? s.shift : hwdata[WORD_W-1:0];

   // Bus address phase accepted
   assign addr_phase = hsel & hready & htrans[1];

   // Per-loop fields; loop 0 is loop_one, latch index is the select code
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LOOP; gi++) begin : g_loop
         localparam int RI = (gi == 0) ? int'(SEL_ONE_R) : int'(SEL_TWO_R);
         localparam int NI = (gi == 0) ? int'(SEL_ONE_N) : int'(SEL_TWO_N);
         assign pd_bit[gi] = s.latch[NI][BIT_PD-SEL_W];
         assign tri_bit[gi] = s.latch[RI][BIT_TRI-SEL_W];
         assign cur_bit[gi] = s.latch[RI][BIT_CUR-SEL_W];
         assign lds_bit[gi] = s.latch[RI][BIT_LDS-SEL_W];
         assign ofs_bit[gi] = s.latch[RI][BIT_OFS-SEL_W];
         // divider word with powerdown bit drives this loop
         assign loop_load[gi] = load_evt && (load_word[SEL_W-1:0] == NI[SEL_W-1:0]);

         ppfac_loop u_loop (
            .clk(clk),
            .rst(rst),
            .load_evt(loop_load[gi]),
            .pd_new(load_word[BIT_PD]),
            .tri_bit(tri_bit[gi]),
            .fast_req(fast_mode & cur_bit[gi]),
            .pump_idle(sync_q[3+gi]),
            .state(loop_st[gi]),
            .powered_down(loop_down[gi]),
            .fast_active(fast_act[gi])
         );

         // dividers held in load while down
         assign divider_load[gi] = loop_down[gi];
         assign prescaler_hiz[gi] = loop_down[gi];
         assign loop_bias_en[gi] = ~loop_down[gi];
         // tristate bit or powerdown floats the pump
         assign pump_tristate[gi] = tri_bit[gi] | loop_down[gi];
         // four times current while fast acquire holds
         assign pump_x4[gi] = fast_mode ? (fast_act[gi] & ~loop_down[gi]) : cur_bit[gi];
      end
   endgenerate

   // fast acquire selected by both loops' mode bits
   assign fast_mode = (lds_bit == 2'h0) && (ofs_bit == 2'h3);

   assign multifunction_output_o = 1'b0;
   assign multifunction_output_oe = fast_mode & |(fast_act & ~loop_down);

   // oscillator off only with both powerdown bits set
   assign osc_enable = ~&pd_bit;

   // Status word of loop states and fast acquire
   always_comb begin
      status = 32'h00000000;
      status[ST_LOOP_LSB +: 2] = loop_st[0];
      status[ST_LOOP_LSB+2 +: 2] = loop_st[1];
      status[ST_OSC] = osc_enable;
      status[ST_FAST_LSB +: NUM_LOOP] = fast_act;
      status[ST_PULL] = multifunction_output_oe;
   end

   // Read mux, evaluated in the address phase
   always_comb begin
      rd_val = 32'h00000000;
      case (haddr[ADDR_W-1:0])
         OFS_STATUS: rd_val = status;
         OFS_LAT_TWO_R: rd_val[DATA_W-1:0] = s.latch[SEL_TWO_R];
         OFS_LAT_ONE_R: rd_val[DATA_W-1:0] = s.latch[SEL_ONE_R];
         OFS_LAT_TWO_N: rd_val[DATA_W-1:0] = s.latch[SEL_TWO_N];
         OFS_LAT_ONE_N: rd_val[DATA_W-1:0] = s.latch[SEL_ONE_N];
         default: rd_val = 32'h00000000;
      endcase
      if (|haddr[31:ADDR_W]) begin
         rd_val = 32'h00000000;
      end
   end

   // Next state of shift register, latches and bus slave
   always_comb begin
      n = s;
      n.sclk_d = sync_q[0];
      n.load_d = sync_q[2];
      // MSB first on serial clock rise
      if (sclk_rise) begin
         n.shift = {s.shift[WORD_W-2:0], sync_q[1]};
      end
      // load edge picks latch by last two bits
      if (load_evt) begin
         n.latch[load_word[SEL_W-1:0]] = load_word[WORD_W-1:SEL_W];
      end
      n.wr_pend = 1'b0;
      if (addr_phase) begin
         n.wr_pend = hwrite;
         n.addr = (|haddr[31:ADDR_W]) ? 8'hff : haddr[ADDR_W-1:0];
         n.rdata = hwrite ? s.rdata : rd_val;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{shift: SHIFT_RST, sclk_d: 1'b0, load_d: 1'b0,
                latch: {NUM_LATCH{LATCH_RST}}, wr_pend: 1'b0, addr: 8'h00,
                rdata: RDATA_RST};
      end else begin
         s <= n;
      end
   end

   // Bus answers and latch outputs
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign ref_word_one = s.latch[SEL_ONE_R];
   assign ref_word_two = s.latch[SEL_TWO_R];
   assign div_word_one = s.latch[SEL_ONE_N];
   assign div_word_two = s.latch[SEL_TWO_N];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_serial_bit;
      sclk_rise;
   endsequence
   sequence s_load_one_n;
      load_rise && s.shift[SEL_W-1:0] == SEL_ONE_N;
   endsequence
   sequence s_load_one_r;
      load_evt && load_word[SEL_W-1:0] == SEL_ONE_R;
   endsequence

   a_shift_msb_first: assert property (s_serial_bit |=> s.shift[0] == $past(sync_q[1])
      && s.shift[WORD_W-1:1] == $past(s.shift[WORD_W-2:0]))
      else $error("Serial bit not shifted in at the bottom");
   a_latch_select: assert property (s_load_one_n
      |=> div_word_one == $past(s.shift[WORD_W-1:2]))
      else $error("Load edge filled the wrong latch");
   a_latch_in_down: assert property (|loop_down && load_rise
      |=> s.latch[$past(s.shift[1:0])] == $past(s.shift[WORD_W-1:2]))
      else $error("Latch ignored while a loop is down");
   a_osc_wake: assert property (s_load_one_n and !s.shift[BIT_PD] |=> osc_enable)
      else $error("Oscillator off after loop_one wake");
   a_div_load_async: assert property (loop_load[0] && load_word[BIT_PD] && tri_bit[0]
      && loop_st[0] == LS_ACTIVE |=> divider_load[0] && prescaler_hiz[0])
      else $error("Dividers not forced to load on powerdown");
   a_other_loop_kept: assert property (loop_load[0] && !loop_load[1]
      |=> loop_st[1] == $past(loop_st[1]) || $past(loop_st[1]) == LS_SYNC_WAIT)
      else $error("Loop_two state moved by a loop_one load");
   a_fast_pull: assert property (fast_mode && cur_bit[0] && !loop_down[0] && !load_evt
      |=> multifunction_output_oe && pump_x4[0] || loop_down[0])
      else $error("Pull-down not on during fast acquire");

   // Async entry of loop_one debiases its prescaler
   a_prescaler_debias: assert property (loop_load[0] && load_word[BIT_PD] && tri_bit[0]
      && loop_st[0] == LS_ACTIVE |=> prescaler_hiz[0] && !loop_bias_en[0])
      else $error("Prescaler not debiased on powerdown");

   // Sync wait of loop_two ends with dividers in load
   a_sync_load_two: assert property (loop_st[1] == LS_SYNC_WAIT && sync_q[4]
      && !loop_load[1] |=> divider_load[1])
      else $error("Loop_two dividers not in load");

   // Cleared powerdown bit wakes loop_one
   a_wake_one: assert property (loop_load[0] && !load_word[BIT_PD]
      |=> loop_bias_en[0] && !divider_load[0])
      else $error("Loop_one not woken");

   // Cleared powerdown bit wakes loop_two
   a_wake_two: assert property (loop_load[1] && !load_word[BIT_PD]
      |=> loop_bias_en[1] && !divider_load[1])
      else $error("Loop_two not woken");

   // Second powerdown bit stops the oscillator
   a_osc_both_off: assert property (loop_load[1] && load_word[BIT_PD] && pd_bit[0]
      |=> !osc_enable)
      else $error("Oscillator on with both powerdown bits set");

   // Waking loop_two restarts the oscillator
   a_osc_on_wake: assert property (loop_load[1] && !load_word[BIT_PD]
      |=> osc_enable)
      else $error("Oscillator off after loop_two wake");

   // Tristate bit floats the loop_one pump
   a_tri_bit_set: assert property (s_load_one_r and load_word[BIT_TRI]
      |=> pump_tristate[0])
      else $error("Pump not floated by tristate bit");

   // Cleared tristate bit lets an active pump drive
   a_tri_bit_clear: assert property (s_load_one_r and !load_word[BIT_TRI]
      && loop_st[0] == LS_ACTIVE |=> !pump_tristate[0])
      else $error("Pump floated on an active loop");

   // Current bit outside fast acquire sets high current
   a_current_normal: assert property (s_load_one_r and load_word[BIT_CUR]
      && load_word[BIT_LDS] |=> pump_x4[0])
      else $error("High current bit ignored");

   // Fast acquire on loop_two raises its current
   a_fast_x4_two: assert property (fast_mode && cur_bit[1] && !loop_down[1] && !load_evt
      |=> pump_x4[1] || loop_down[1])
      else $error("Loop_two pump not at high current");

   // Lock select set forbids fast acquire
   a_fast_lds_off: assert property (s_load_one_r and load_word[BIT_LDS]
      |=> !multifunction_output_oe)
      else $error("Pull-down on with lock select set");

   // Output select cleared forbids fast acquire
   a_fast_ofs_off: assert property (load_evt && load_word[SEL_W-1:0] == SEL_TWO_R
      && !load_word[BIT_OFS] |=> !multifunction_output_oe)
      else $error("Pull-down on with output select cleared");

   // Released fast acquire ends when the pump is idle
   a_fast_release: assert property (fast_act[0] && !(fast_mode && cur_bit[0])
      && sync_q[3] |=> !fast_act[0])
      else $error("Fast acquire kept with pump idle");

   // No pull-down outside fast acquire mode
   a_pull_off_normal: assert property (!fast_mode && !load_evt
      |=> !multifunction_output_oe)
      else $error("Pull-down on outside fast acquire");

   // Shifting continues while a loop is down
   a_shift_in_down: assert property (|loop_down && sclk_rise
      |=> s.shift[0] == $past(sync_q[1]))
      else $error("Serial bit lost while a loop is down");

   // Bus load word lands in the selected latch
   a_bus_load_latch: assert property (bus_load && !load_rise
      |=> s.latch[$past(hwdata[1:0])] == $past(hwdata[WORD_W-1:2]))
      else $error("Bus load missed its latch");

   // A loop_two load leaves loop_one alone
   a_other_loop_one: assert property (loop_load[1]
      |=> loop_st[0] == $past(loop_st[0]) || $past(loop_st[0]) == LS_SYNC_WAIT)
      else $error("Loop_one state moved by a loop_two load");

   // Loads to other latches keep the loop_one reference
   a_ref_latch_kept: assert property (load_evt && load_word[SEL_W-1:0] != SEL_ONE_R
      |=> ref_word_one == $past(ref_word_one))
      else $error("Reference latch changed by another select");
endmodule
`default_nettype wire

// ---- inc/ppfac_pkg.sv ----
// Package for the synthesizer powerdown and fast-acquire control block.
// Assumes one 40 MHz clock; serial pins and pump status arrive asynchronously.
package ppfac_pkg;
   // Serial word: 20 data bits above two select bits
   localparam int WORD_W = 22;
   localparam int DATA_W = 20;
   localparam int SEL_W = 2;
   localparam int NUM_LATCH = 4;
   localparam int NUM_LOOP = 2;
   // Field positions inside the shifted word
   localparam int BIT_PD = 21;
   localparam int BIT_CUR = 18;
   localparam int BIT_TRI = 19;
   localparam int BIT_LDS = 20;
   localparam int BIT_OFS = 21;
   // Latch select codes
   localparam logic [1:0] SEL_TWO_R = 2'h0;
   localparam logic [1:0] SEL_ONE_R = 2'h1;
   localparam logic [1:0] SEL_TWO_N = 2'h2;
   localparam logic [1:0] SEL_ONE_N = 2'h3;
   // Bus register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_LOAD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LAT_TWO_R = 8'h08;
   localparam logic [7:0] OFS_LAT_ONE_R = 8'h0c;
   localparam logic [7:0] OFS_LAT_TWO_N = 8'h10;
   localparam logic [7:0] OFS_LAT_ONE_N = 8'h14;
   // Status field positions
   localparam int ST_LOOP_LSB = 0;
   localparam int ST_OSC = 4;
   localparam int ST_FAST_LSB = 5;
   localparam int ST_PULL = 7;
   // Reset values
   localparam logic [DATA_W-1:0] LATCH_RST = 20'h00000;
   localparam logic [WORD_W-1:0] SHIFT_RST = 22'h000000;
   localparam logic [31:0] RDATA_RST = 32'h00000000;
   // Loop power state
   typedef enum logic [1:0] {
      LS_ACTIVE = 2'b00,
      LS_SYNC_WAIT = 2'b01,
      LS_DOWN = 2'b10
   } ppfac_loop_state_t;
endpackage

// ---- tb/ppfac_host.sv ----
// Host-side model that programs the controller through its three-wire pins.
// Assumes the bench calls send right after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module ppfac_host (
   input wire logic clk, // System clock used for pacing
   output logic ser_clk, // Serial shift clock
   output logic ser_data, // Serial data
   output logic load_enable // Load enable pulse
);
   // Idle levels at time zero, clock stands low between frames
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_enable = 1'b0;
   end

   // Wait a number of system clocks
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   // MSB first, select last
   // Each level is held four clocks so the synchronizer sees every edge
   task automatic send(input logic [21:0] w);
      for (int i = 21; i >= 0; i--) begin
         ser_data <= w[i];
         hold(4);
         ser_clk <= 1'b1;
         hold(4);
         ser_clk <= 1'b0;
      end
      hold(4);
      ser_data <= ~w[0]; // Data no longer valid after the frame
      load_enable <= 1'b1;
      hold(4);
      load_enable <= 1'b0;
      hold(4);
   endtask
endmodule
`default_nettype wire

// ---- tb/ppfac_top_tb.sv ----
// Self-checking bench for the powerdown and fast-acquire controller.
// Assumes the host model drives the serial pins; the bench is bus master.
`timescale 1ns/10ps
`default_nettype none
module ppfac_top_tb;
   import ppfac_pkg::*;
   typedef struct packed {
      logic [21:0] word;
      logic [1:0] bias;
      logic [1:0] tri_st;
      logic [1:0] dload;
      logic osc;
   } ppfac_row_t;
   logic clk, rst, ser_clk, ser_data, load_enable, hsel, hwrite, hready;
   logic [1:0] pump_idle, htrans, bias, dload, phiz, ptri, px4;
   logic osc, mfo, mfo_oe, hreadyout, hresp;
   logic [19:0] rw1, rw2, dw1, dw2;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [2:0] hsize;
   int n_fail = 0;
   int compares = 0;
   ppfac_row_t rows [5];

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   ppfac_host host (
      .clk(clk),
      .ser_clk(ser_clk),
      .ser_data(ser_data),
      .load_enable(load_enable)
   );

   ppfac_top DUT (
      .clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_enable(load_enable), .pump_idle(pump_idle), .loop_bias_en(bias),
      .divider_load(dload), .prescaler_hiz(phiz), .pump_tristate(ptri),
      .pump_x4(px4), .osc_enable(osc), .multifunction_output_o(mfo),
      .multifunction_output_oe(mfo_oe), .ref_word_one(rw1), .ref_word_two(rw2),
      .div_word_one(dw1), .div_word_two(dw2), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
   );

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Print counts and verdict, then stop
   task automatic complete_run();
      $display("n_fail=%0d compares=%0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compare seen against expected, report on difference
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Advance until hready is sampled high, bounded
   task automatic hold_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         n_fail++;
         complete_run();
      end
   endtask

   // One single word transfer: address phase, then data phase
   task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      hold_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      hold_ready();
      d = hrdata;
   endtask

   // Wait for the loop power or pump current outputs to reach a value
   task automatic wait_for(input logic [1:0] exp, input bit on_x4);
      int n;
      n = 0;
      while (((on_x4 ? px4 : bias) !== exp) && n < 100) begin
         @(posedge clk);
         n++;
      end
      if ((on_x4 ? px4 : bias) !== exp) begin
         n_fail++;
         complete_run();
      end
   endtask

   // Latch output addressed by a select code
   function automatic logic [19:0] latch_of(input logic [1:0] s);
      case (s)
         2'h0: return rw2;
         2'h1: return rw1;
         2'h2: return dw2;
         default: return dw1;
      endcase
   endfunction

   // Main sequence
   initial begin
      rst = 1'b1;
      pump_idle = 2'h0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rows = '{
         '{22'h080001, 2'h3, 2'h1, 2'h0, 1'b1},
         '{22'h200003, 2'h2, 2'h1, 2'h1, 1'b1},
         '{22'h200002, 2'h2, 2'h1, 2'h1, 1'b0},
         '{22'h000003, 2'h3, 2'h1, 2'h0, 1'b1},
         '{22'h000001, 2'h3, 2'h0, 2'h0, 1'b1}
      };
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset state: both loops up, oscillator on, pull-down off
      check(bias, 2'h3);
      check(mfo_oe, 1'b0);
      check(hresp, 1'b0);
      bus(OFS_STATUS, 1'b0, 32'h0, rd);
      check(rd, 32'h10);
      // Table of loads: mode bits, powerdown kinds, oscillator, latches
      foreach (rows[i]) begin
         bus(OFS_LOAD, 1'b1, {10'h0, rows[i].word}, rd);
         repeat (3) @(posedge clk);
         check(bias, rows[i].bias);
         check(ptri, rows[i].tri_st);
         check(dload, rows[i].dload);
         check(osc, rows[i].osc);
         check(latch_of(rows[i].word[1:0]), rows[i].word[21:2]);
      end
      pump_idle <= 2'h2;
      wait_for(2'h1, 1'b0);
      check(dload, 2'h2);
      check(phiz, 2'h2);
      check(ptri, 2'h2);
      check(osc, 1'b1);
      // serial wake of a down loop
      pump_idle <= 2'h0;
      host.send(22'h168f06);
      repeat (6) @(posedge clk);
      check(dw2, 20'h5a3c1);
      check(bias, 2'h3);
      check(dload, 2'h0);
      host.send(22'h0f0f0f);
      repeat (6) @(posedge clk);
      check(dw1, 20'h3c3c3);
      check(osc, 1'b1);
      bus(OFS_LOAD, 1'b1, 32'h200000, rd);
      bus(OFS_LOAD, 1'b1, 32'h240001, rd);
      repeat (3) @(posedge clk);
      check(px4, 2'h1);
      check(mfo_oe, 1'b1);
      check(mfo, 1'b0);
      bus(OFS_STATUS, 1'b0, 32'h0, rd);
      check(rd, 32'hb0);
      check(rw2, 20'h80000);
      check(hreadyout, 1'b1);
      // bench clears the current bit over the bus; release waits for the pump
      bus(OFS_LOAD, 1'b1, 32'h200001, rd);
      repeat (4) @(posedge clk);
      check(px4, 2'h1);
      pump_idle <= 2'h1;
      wait_for(2'h0, 1'b1);
      check(mfo_oe, 1'b0);
      // lock select set: no fast acquire
      pump_idle <= 2'h0;
      bus(OFS_LOAD, 1'b1, 32'h340001, rd);
      repeat (3) @(posedge clk);
      check(mfo_oe, 1'b0);
      check(px4, 2'h1);
      // Mid-run reset clears latches and wakes both loops
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(rw1, 20'h0);
      check(px4, 2'h0);
      check(bias, 2'h3);
      bus(32'h18, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
